// >>> inc/asqk_defs.vh
// register offsets, fields and constants of the audio serial port
`ifndef ASQK_DEFS_VH
`define ASQK_DEFS_VH
`define ASQK_OFF_CTRL 8'h00
`define ASQK_OFF_CFG 8'h04
`define ASQK_OFF_TASK 8'h08
`define ASQK_OFF_STATUS 8'h0C
`define ASQK_OFF_MASK 8'h10
`define ASQK_OFF_LIMIT 8'h14
`define ASQK_OFF_TXL 8'h18
`define ASQK_OFF_TXR 8'h1C
`define ASQK_OFF_RXL 8'h20
`define ASQK_OFF_RXR 8'h24
`define ASQK_OFF_STATE 8'h28
`define ASQK_CTRL_RXEN 0
`define ASQK_CTRL_TXEN 1
`define ASQK_CFG_SLAVE 0
`define ASQK_CFG_STEREO 1
`define ASQK_CFG_ALIGNED 2
`define ASQK_TASK_START 0
`define ASQK_TASK_STOP 1
`define ASQK_EV_RXPTR 0
`define ASQK_EV_TXPTR 1
`define ASQK_EV_STOPPED 2
`define ASQK_EV_W 3
`define ASQK_SAMPLE_W 16
`define ASQK_CNT_W 16
`define ASQK_LIMIT_RST 16'h0001
`define ASQK_DIV_LAST 3'h7
`define ASQK_WS_LAST 5'h0F
`endif

// >>> hw/asqk_sync.v
// two flip-flop synchroniser for one level
`timescale 1ns/1ps
`default_nettype none
module asqk_sync
(
  input wire i_clk_sys,
  input wire i_rst_n,
  input wire i_d,
  output wire o_q
);
  reg meta_r;
  reg sync_r;
  always @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
    end
    else
    begin
      meta_r <= i_d;
      sync_r <= meta_r;
    end
  end
  assign o_q = sync_r;
endmodule // asqk_sync
`default_nettype wire

// >>> hw/asqk_evflag.v
// sticky event flag, set wins over write-one clear
`timescale 1ns/1ps
`default_nettype none
module asqk_evflag
(
  input wire i_clk_sys,
  input wire i_rst_n,
  input wire i_set,
  input wire i_clr,
  output wire o_flag
);
  reg flag_r;
  always @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
      flag_r <= 1'b0;
    else if (i_set)
      flag_r <= 1'b1;
    else if (i_clr)
      flag_r <= 1'b0;
  end
  assign o_flag = flag_r;
endmodule // asqk_evflag
`default_nettype wire

// >>> hw/asqk_port.v
// audio serial port core with channel quirks and pointer-update events
//
// Added by the designer: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "asqk_defs.vh"

// Notes on behaviour
// R01 - slave stereo aligned: left sent in both slots
// R02 - aligned format exchanges left and right slots
// R03 - stop raises rx event if rx ran before
// R04 - stop raises tx event if tx ran before
// R05 - stop-raised event does not mean limit reached
// R06 - software ignores and clears events after stop
// R07 - software stores samples exchanged when aligned
// R08 - pointer-update events stay set until cleared
module asqk_port
(
  input wire i_clk_sys,
  input wire i_rst_n,
  input wire [7:0] i_addr,
  input wire [31:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [31:0] o_rdata,
  output wire o_irq,
  input wire i_sck_in,
  input wire i_word_select_clock_in,
  input wire i_sdin,
  output wire o_sck_out,
  output wire o_word_select_clock_out,
  output wire o_word_select_clock_oe,
  output wire o_sck_oe,
  output reg o_sdout
);
  // ----------------------------------------
  // registers
  // ----------------------------------------
  reg rx_en_r;
  reg tx_en_r;
  reg slave_r;
  reg stereo_r;
  reg aligned_r;
  reg [`ASQK_CNT_W-1:0] limit_r;
  reg [`ASQK_EV_W-1:0] mask_r;
  reg [`ASQK_SAMPLE_W-1:0] txl_r;
  reg [`ASQK_SAMPLE_W-1:0] txr_r;
  reg [`ASQK_SAMPLE_W-1:0] rxl_r;
  reg [`ASQK_SAMPLE_W-1:0] rxr_r;
  reg running_r;
  reg rx_ran_r;
  reg tx_ran_r;
  reg limit_hit_r;
  reg [`ASQK_CNT_W-1:0] rx_cnt_r;
  reg [`ASQK_CNT_W-1:0] tx_cnt_r;
  wire [`ASQK_EV_W-1:0] ev_flag;
  wire [`ASQK_EV_W-1:0] ev_set;
  wire [`ASQK_EV_W-1:0] ev_clr;
  wire wr_task = i_wr && (i_addr == `ASQK_OFF_TASK);
  wire start_req = wr_task && i_wdata[`ASQK_TASK_START];
  wire stop_req = wr_task && i_wdata[`ASQK_TASK_STOP];

  // ----------------------------------------
  // link inputs, two flops each
  // ----------------------------------------
  wire sck_s;
  wire ws_s;
  wire sdin_s;
  asqk_sync u_sync_sck (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_d(i_sck_in), .o_q(sck_s));
  asqk_sync u_sync_ws (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_d(i_word_select_clock_in), .o_q(ws_s));
  asqk_sync u_sync_sd (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_d(i_sdin), .o_q(sdin_s));

  // master clock: divide by 8 so a bit is 16 system cycles
  reg [2:0] div_r;
  reg sck_gen_r;
  reg [4:0] ws_div_r;
  reg ws_gen_r;
  always @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      div_r <= 3'h0;
      sck_gen_r <= 1'b0;
      ws_div_r <= 5'h00;
      ws_gen_r <= 1'b0;
    end
    else if (running_r && !slave_r)
    begin
      div_r <= div_r + 3'h1;
      if (div_r == `ASQK_DIV_LAST)
      begin
        sck_gen_r <= ~sck_gen_r;
        if (sck_gen_r)
        begin
          ws_div_r <= ws_div_r + 5'h01;
          if (ws_div_r == `ASQK_WS_LAST)
            ws_gen_r <= ~ws_gen_r;
        end
      end
    end
    else
    begin
      div_r <= 3'h0;
      sck_gen_r <= 1'b0;
      ws_div_r <= 5'h00;
      ws_gen_r <= 1'b0;
    end
  end
  assign o_sck_out = sck_gen_r;
  assign o_word_select_clock_out = ws_gen_r;
  assign o_sck_oe = running_r && !slave_r;
  assign o_word_select_clock_oe = running_r && !slave_r;

  // ----------------------------------------
  // bit engine
  // ----------------------------------------
  wire sck_cur = slave_r ? sck_s : sck_gen_r;
  wire ws_cur = slave_r ? ws_s : ws_gen_r;
  reg sck_d_r;
  reg ws_d_r;
  wire sck_rise = sck_cur && !sck_d_r;
  wire sck_fall = !sck_cur && sck_d_r;
  wire ws_edge = ws_cur != ws_d_r;
  // aligned format flips which slot the word select level names
  wire slot_right = aligned_r ? !ws_cur : ws_cur; // R02
  // slave stereo aligned repeats the left sample in both slots
  wire dup_left = slave_r && stereo_r && aligned_r; // R01
  wire [`ASQK_SAMPLE_W-1:0] slot_data = (slot_right && !dup_left) ? txr_r : txl_r; // R01
  reg [`ASQK_SAMPLE_W-1:0] tx_sh_r;
  reg [`ASQK_SAMPLE_W-1:0] rx_sh_r;
  reg slot_right_r;
  reg word_done_r;
  always @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      sck_d_r <= 1'b0;
      ws_d_r <= 1'b0;
      tx_sh_r <= 16'h0000;
      rx_sh_r <= 16'h0000;
      rxl_r <= 16'h0000;
      rxr_r <= 16'h0000;
      slot_right_r <= 1'b0;
      word_done_r <= 1'b0;
      o_sdout <= 1'b0;
    end
    else
    begin
      sck_d_r <= sck_cur;
      word_done_r <= 1'b0;
      if (sck_fall && running_r)
      begin
        ws_d_r <= ws_cur;
        if (ws_edge)
        begin
          // a new slot: latch the finished word, load the next one
          if (rx_en_r)
          begin
            if (slot_right_r)
              rxr_r <= rx_sh_r;
            else
              rxl_r <= rx_sh_r;
          end
          word_done_r <= 1'b1;
          slot_right_r <= slot_right;
          tx_sh_r <= {slot_data[`ASQK_SAMPLE_W-2:0], 1'b0};
          o_sdout <= tx_en_r ? slot_data[`ASQK_SAMPLE_W-1] : 1'b0;
        end
        else
        begin
          tx_sh_r <= {tx_sh_r[`ASQK_SAMPLE_W-2:0], 1'b0};
          o_sdout <= tx_en_r ? tx_sh_r[`ASQK_SAMPLE_W-1] : 1'b0;
        end
      end
      if (sck_rise && running_r)
        rx_sh_r <= {rx_sh_r[`ASQK_SAMPLE_W-2:0], sdin_s};
    end
  end

  // ----------------------------------------
  // word counts and pointer-update events
  // ----------------------------------------
  wire rx_limit = word_done_r && rx_en_r && (rx_cnt_r + 16'h0001 >= limit_r);
  wire tx_limit = word_done_r && tx_en_r && (tx_cnt_r + 16'h0001 >= limit_r);
  always @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      running_r <= 1'b0;
      rx_ran_r <= 1'b0;
      tx_ran_r <= 1'b0;
      rx_cnt_r <= 16'h0000;
      tx_cnt_r <= 16'h0000;
      limit_hit_r <= 1'b0;
    end
    else
    begin
      if (start_req)
      begin
        running_r <= 1'b1;
        rx_cnt_r <= 16'h0000;
        tx_cnt_r <= 16'h0000;
      end
      else if (stop_req)
        running_r <= 1'b0;
      if (running_r && rx_en_r)
        rx_ran_r <= 1'b1;
      if (running_r && tx_en_r)
        tx_ran_r <= 1'b1;
      if (rx_limit)
        rx_cnt_r <= 16'h0000;
      else if (word_done_r && rx_en_r)
        rx_cnt_r <= rx_cnt_r + 16'h0001;
      if (tx_limit)
        tx_cnt_r <= 16'h0000;
      else if (word_done_r && tx_en_r)
        tx_cnt_r <= tx_cnt_r + 16'h0001;
      // a stop-raised event is spurious: the limit flag says so
      if (stop_req)
        limit_hit_r <= 1'b0; // R05
      else if (rx_limit || tx_limit)
        limit_hit_r <= 1'b1;
    end
  end
  // spurious events on stop stay as the silicon has them
  assign ev_set[`ASQK_EV_RXPTR] = rx_limit || (stop_req && rx_ran_r); // R03
  assign ev_set[`ASQK_EV_TXPTR] = tx_limit || (stop_req && tx_ran_r); // R04
  assign ev_set[`ASQK_EV_STOPPED] = stop_req && running_r;
  assign ev_clr = (i_wr && (i_addr == `ASQK_OFF_STATUS)) ? i_wdata[`ASQK_EV_W-1:0] : 3'h0;
  genvar gi;
  generate
    for (gi = 0; gi < `ASQK_EV_W; gi = gi + 1)
    begin : g_ev
      asqk_evflag u_ev (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_set(ev_set[gi]), .i_clr(ev_clr[gi]),
        .o_flag(ev_flag[gi])); // R08
    end
  endgenerate
  assign o_irq = |(ev_flag & mask_r);

  // ----------------------------------------
  // register bus
  // ----------------------------------------
  always @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      rx_en_r <= 1'b0;
      tx_en_r <= 1'b0;
      slave_r <= 1'b0;
      stereo_r <= 1'b0;
      aligned_r <= 1'b0;
      limit_r <= `ASQK_LIMIT_RST;
      mask_r <= 3'h0;
      txl_r <= 16'h0000;
      txr_r <= 16'h0000;
    end
    else if (i_wr)
    begin
      case (i_addr)
        `ASQK_OFF_CTRL:
        begin
          rx_en_r <= i_wdata[`ASQK_CTRL_RXEN];
          tx_en_r <= i_wdata[`ASQK_CTRL_TXEN];
        end
        `ASQK_OFF_CFG:
        begin
          slave_r <= i_wdata[`ASQK_CFG_SLAVE];
          stereo_r <= i_wdata[`ASQK_CFG_STEREO];
          aligned_r <= i_wdata[`ASQK_CFG_ALIGNED];
        end
        `ASQK_OFF_MASK: mask_r <= i_wdata[`ASQK_EV_W-1:0];
        `ASQK_OFF_LIMIT: limit_r <= i_wdata[`ASQK_CNT_W-1:0];
        `ASQK_OFF_TXL: txl_r <= i_wdata[`ASQK_SAMPLE_W-1:0];
        `ASQK_OFF_TXR: txr_r <= i_wdata[`ASQK_SAMPLE_W-1:0];
        default: ;
      endcase
    end
  end

  always @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_rdata <= 32'h00000000;
    else if (i_rd)
    begin
      case (i_addr)
        `ASQK_OFF_CTRL: o_rdata <= {30'h0, tx_en_r, rx_en_r};
        `ASQK_OFF_CFG: o_rdata <= {29'h0, aligned_r, stereo_r, slave_r};
        `ASQK_OFF_STATUS: o_rdata <= {29'h0, ev_flag};
        `ASQK_OFF_MASK: o_rdata <= {29'h0, mask_r};
        `ASQK_OFF_LIMIT: o_rdata <= {16'h0, limit_r};
        `ASQK_OFF_TXL: o_rdata <= {16'h0, txl_r};
        `ASQK_OFF_TXR: o_rdata <= {16'h0, txr_r};
        `ASQK_OFF_RXL: o_rdata <= {16'h0, rxl_r};
        `ASQK_OFF_RXR: o_rdata <= {16'h0, rxr_r};
        `ASQK_OFF_STATE: o_rdata <= {28'h0, limit_hit_r, tx_ran_r, rx_ran_r, running_r};
        default: o_rdata <= 32'h00000000;
      endcase
    end
    else
      o_rdata <= 32'h00000000;
  end
endmodule // asqk_port
`default_nettype wire

// >>> bench/asqk_port_checker.sv
// register-side checker of the audio serial port
`timescale 1ns/1ps
`default_nettype none
`include "asqk_defs.vh"
module asqk_port_checker
(
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [31:0] o_rdata,
  input wire logic o_irq
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  logic run_r, rx_ran_r, tx_ran_r;
  logic [1:0] ctrl_r;
  logic [2:0] mask_r;
  wire logic stop_w = i_wr && i_addr == `ASQK_OFF_TASK && i_wdata[`ASQK_TASK_STOP];
  wire logic clr_w = i_wr && (i_addr == `ASQK_OFF_STATUS || i_addr == `ASQK_OFF_MASK);
  // ran flags are set in the same cycle as the design's, so the stop checks follow its events
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
    if (!i_rst_n)
    begin
      run_r <= 1'b0;
      rx_ran_r <= 1'b0;
      tx_ran_r <= 1'b0;
      ctrl_r <= 2'h0;
      mask_r <= 3'h0;
    end
    else
    begin
      if (i_wr && i_addr == `ASQK_OFF_TASK)
        run_r <= (run_r | i_wdata[0]) & ~i_wdata[1];
      if (i_wr && i_addr == `ASQK_OFF_CTRL)
        ctrl_r <= i_wdata[1:0];
      if (i_wr && i_addr == `ASQK_OFF_MASK)
        mask_r <= i_wdata[2:0];
      rx_ran_r <= rx_ran_r | (run_r & ctrl_r[0]);
      tx_ran_r <= tx_ran_r | (run_r & ctrl_r[1]);
    end
  a_stop_rx_event: assert property (stop_w && rx_ran_r && mask_r[0] |=> ##[0:1] o_irq)
    else $error("rx event missing after stop");
  a_stop_tx_event: assert property (stop_w && tx_ran_r && mask_r[1] |=> ##[0:1] o_irq)
    else $error("tx event missing after stop");
  a_limit_false: assert property (i_rd && i_addr == `ASQK_OFF_STATE && $past(stop_w) |=> !o_rdata[3])
    else $error("limit flag after stop");
  a_event_sticky: assert property (o_irq && !clr_w |=> o_irq)
    else $error("event dropped without clear");
  a_mask_quiet: assert property (mask_r == 3'h0 |-> !o_irq)
    else $error("irq while all masked");
  a_read_idle: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
    else $error("read data outside answer");
  c_stop_ran: cover property (stop_w && rx_ran_r);
  c_irq: cover property (o_irq);
  c_read: cover property (i_rd ##1 o_rdata != 32'h0);
endmodule // asqk_port_checker
bind asqk_port asqk_port_checker i_asqk_port_checker (.i_clk_sys, .i_rst_n, .i_addr, .i_wdata, .i_wr, .i_rd,
  .o_rdata, .o_irq);
`default_nettype wire

// >>> bench/asqk_codec_model.sv
// behavioural codec at the far end of the serial link
`timescale 1ns/1ps
`default_nettype none
module asqk_codec_model
(
  input wire logic i_run,
  input wire logic i_sck_line,
  input wire logic i_ws_line,
  input wire logic i_sdo,
  output logic o_sck,
  output logic o_ws,
  output logic o_sd,
  output logic [15:0] o_word_hi,
  output logic [15:0] o_word_lo,
  output int o_nwords
);
  int nbit = 0;
  logic ws_q = 1'b0;
  logic [15:0] sh = 16'h0;
  initial
  begin
    o_sck = 1'b0;
    o_ws = 1'b0;
    o_sd = 1'b0;
    o_nwords = 0;
  end
  // clock stands low while run is low, with no gap between words; 64 ns bit period, word select moves on falling edge
  always
  begin
    wait (i_run === 1'b1);
    repeat (16)
    begin
      #32 o_sck = 1'b1;
      #32 o_sck = 1'b0;
      o_sd = ~o_sd;
    end
    o_ws = ~o_ws;
  end
  // left-justified capture: first bit follows the word select change
  always @(posedge i_sck_line)
  begin
    if (i_ws_line !== ws_q)
      nbit = 0;
    ws_q = i_ws_line;
    sh = {sh[14:0], i_sdo};
    nbit++;
    if (nbit == 16)
    begin
      if (ws_q)
        o_word_hi = sh;
      else
        o_word_lo = sh;
      o_nwords++;
    end
  end
endmodule // asqk_codec_model
`default_nettype wire

// >>> bench/asqk_port_tb.sv
// self-checking bench of the audio serial port
`timescale 1ns/1ps
`default_nettype none
`include "asqk_defs.vh"
module asqk_port_tb;
  logic i_clk_sys = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic run = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0, o_rdata, rv;
  logic o_irq, o_sck_out, o_sck_oe, o_sdout, o_word_select_clock_out, o_word_select_clock_oe, p_sck, p_ws, p_sd;
  logic [15:0] w_hi, w_lo, smp_l, smp_r;
  logic [31:0] cfg;
  int n_words, base, bad_count = 0, n_compared = 0;
  int cfg_q[$] = '{7, 6, 0, 5};
  wire logic i_sck_in = o_sck_oe ? o_sck_out : p_sck;
  wire logic i_word_select_clock_in = o_word_select_clock_oe ? o_word_select_clock_out : p_ws;
  wire logic i_sdin = p_sd;
  always #2.5 i_clk_sys = ~i_clk_sys;
  asqk_port i_asqk_port (.i_clk_sys, .i_rst_n, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .o_irq, .i_sck_in,
    .i_word_select_clock_in, .i_sdin, .o_sck_out, .o_word_select_clock_out, .o_word_select_clock_oe, .o_sck_oe,
    .o_sdout);
  asqk_codec_model i_asqk_codec_model (.i_run(run), .i_sck_line(i_sck_in), .i_ws_line(i_word_select_clock_in),
    .i_sdo(o_sdout), .o_sck(p_sck), .o_ws(p_ws), .o_sd(p_sd), .o_word_hi(w_hi), .o_word_lo(w_lo),
    .o_nwords(n_words));
  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // write strobe is left high so back-to-back writes never assign it twice in a step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_addr <= a;
    i_wdata <= d;
    i_rd <= 1'b0;
    i_wr <= 1'b1;
    @(posedge i_clk_sys);
  endtask
  task automatic rd(input logic [7:0] a);
    i_addr <= a;
    i_wr <= 1'b0;
    i_rd <= 1'b1;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    @(negedge i_clk_sys);
    rv = o_rdata;
    @(posedge i_clk_sys);
  endtask
  task automatic irq_is(input logic e);
    i_wr <= 1'b0;
    @(negedge i_clk_sys);
    chk({31'h0, o_irq}, {31'h0, e});
    @(posedge i_clk_sys);
  endtask
  initial
  begin
    void'($urandom(59256));
    repeat (8) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    @(posedge i_clk_sys);
    rd(`ASQK_OFF_MASK);
    chk(rv, 32'h0);
    rd(`ASQK_OFF_LIMIT);
    chk(rv, {16'h0, `ASQK_LIMIT_RST});
    rd(8'h3C);
    chk(rv, 32'h0);
    wr(`ASQK_OFF_MASK, 32'h3);
    foreach (cfg_q[k])
    begin
      cfg = 32'(cfg_q[k]);
      smp_l = 16'($urandom);
      smp_r = 16'($urandom);
      wr(`ASQK_OFF_TXL, {16'h0, smp_l});
      wr(`ASQK_OFF_TXR, {16'h0, smp_r});
      wr(`ASQK_OFF_CFG, cfg);
      wr(`ASQK_OFF_CTRL, 32'h3);
      wr(`ASQK_OFF_STATUS, 32'h7);
      wr(`ASQK_OFF_TASK, 32'h1);
      irq_is(1'b0);
      run <= cfg[0];
      base = n_words;
      for (int i = 0; i < 5000 && n_words < base + 6; i++)
        @(posedge i_clk_sys);
      if (n_words < base + 6)
      begin
        bad_count++;
        tally_and_finish();
      end
      // word select high carries the stored left sample only when aligned
      chk({16'h0, w_hi}, {16'h0, cfg[2] ? smp_l : smp_r});
      chk({16'h0, w_lo}, {16'h0, (cfg[2] && !(cfg[0] && cfg[1])) ? smp_r : smp_l});
      @(negedge i_clk_sys);
      chk({30'h0, o_sck_oe, o_word_select_clock_oe}, cfg[0] ? 32'h0 : 32'h3);
      @(posedge i_clk_sys);
      run <= 1'b0;
      wr(`ASQK_OFF_TASK, 32'h2);
    end
    wr(`ASQK_OFF_CTRL, 32'h0);
    wr(`ASQK_OFF_STATUS, 32'h7);
    wr(`ASQK_OFF_TASK, 32'h1);
    wr(`ASQK_OFF_TASK, 32'h2);
    rd(`ASQK_OFF_STATE);
    chk({31'h0, rv[3]}, 32'h0);
    rd(`ASQK_OFF_STATUS);
    chk(rv & 32'h3, 32'h3);
    irq_is(1'b1);
    wr(`ASQK_OFF_MASK, 32'h0);
    irq_is(1'b0);
    wr(`ASQK_OFF_MASK, 32'h3);
    i_wr <= 1'b0;
    repeat (20) @(posedge i_clk_sys);
    rd(`ASQK_OFF_STATUS);
    chk(rv & 32'h3, 32'h3);
    wr(`ASQK_OFF_STATUS, 32'h3);
    irq_is(1'b0);
    rd(`ASQK_OFF_STATUS);
    chk(rv & 32'h3, 32'h0);
    tally_and_finish();
  end
endmodule // asqk_port_tb
`default_nettype wire
